// file: logic/pfs_consts.svh
/*
 constants for the port function select block: offsets, fields, reset values.
 assumes inclusion by bare name from the package and the design module.
*/
`ifndef PFS_CONSTS_SVH
`define PFS_CONSTS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PFS_PORT1_FUNCTION_SELECT_OFS 8'h34
`define PFS_PORT2_FUNCTION_SELECT_OFS 8'h38
`define PFS_PORT3_FUNCTION_SELECT_OFS 8'h3c
`define PFS_PORT4_FUNCTION_SELECT_OFS 8'h40

// ----------------------------------------
// field positions
// ----------------------------------------
`define PFS_MAIN_LSB 0
`define PFS_ALT_LSB 8
`define PFS_SCHMITT_LSB 16
`define PFS_FIELD_W 8
`define PFS_IMPL_MASK 32'h00ff_ffff

// ----------------------------------------
// reset values
// ----------------------------------------
`define PFS_PORT123_RST 24'h00_0000
`define PFS_PORT4_RST 24'h00_00c0

`endif

// file: logic/pfs_pkg.sv
/*
 types of the port function select block.
 assumes pfs_consts.svh on the include path.
*/
`include "pfs_consts.svh"

package pfs_pkg;

    // one port selection register, implemented bits only
    typedef struct packed {
        logic [7:0] schmitt_input_enable;
        logic [7:0] alternate_select;
        logic [7:0] main_select;
    } pfs_sel_t;

    // per-pin function code
    typedef enum logic [1:0] {
        PFS_FN_GPIO,
        PFS_FN_MAIN,
        PFS_FN_ALT,
        PFS_FN_RSVD
    } pfs_fn_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } pfs_req_t;

    typedef struct packed {
        pfs_sel_t [3:0] sel;
        logic [31:0] rdata;
    } pfs_state_t;

endpackage : pfs_pkg

// file: logic/pfs_port_function_select.sv
/*
 port function select: selection registers for ports 1 to 4 and the pin
 function decode that steers gpio, peripheral and schmitt enables per pin.
 assumes a simple register port driven synchronously to sys_clk, and that
 peripherals and pad logic consume the per-pin decoded selects.
*/
// Our own choice: strobed register access.
// Notes on behaviour
// RULE1 - each register: schmitt bits 23:16, alternate 15:8, main 7:0, 31:24 reserved.
// RULE2 - schmitt bit one enables the pin's schmitt input buffer, zero disables.
// RULE3 - function decoded from alternate and main bits; both clear keeps gpio.
// RULE4 - port 1 main only routes pin n to analog channel n.
// RULE5 - port 1 alternate only: pins 4..7 are serial0 select, mosi, miso, clock.
// RULE6 - port 1 alternate only: pin2 uart1 rx, pin3 tx, pin0 timer2, pin1 timer3.
// RULE7 - port 2 main only routes pin n to external bus address/data bit 8+n.
// RULE8 - port 2 alternate only routes pin n to pwm output n.
// RULE9 - port 3 main only: pin0 uart0 rx, pin1 tx; alternate there reserved.
// RULE10 - port 3 main: pins 2,3 external irq 0,1; pin3 alternate is bus clock.
// RULE11 - port 3 main: pins 4,5 timer0,1; alternate: pin4 sda, pin5 scl.
// RULE12 - port 3 main: pin6 write strobe, pin7 read strobe; pin6 alternate clock out.
// RULE13 - port 4 main only: pins 0..3 pwm outputs 0..3; alternate reserved.
// RULE14 - port 4 main only: pin4 bus chip select, pin5 address latch enable.
// RULE15 - port 4 main only: pin6 debug clock, pin7 debug data.
// RULE16 - port 4 register resets with main bits 6 and 7 set.
// RULE17 - ports 1 to 3 registers reset to zero.
// RULE18 - bits 31:24 read zero and ignore writes.
`timescale 1ns/10ps
`default_nettype none
`include "pfs_consts.svh"

module pfs_port_function_select
    import pfs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic [7:0] p1_schmitt_input_enable,
    output logic [7:0] p2_schmitt_input_enable,
    output logic [7:0] p3_schmitt_input_enable,
    output logic [7:0] p4_schmitt_input_enable,
    output logic [7:0] p1_gpio_sel,
    output logic [7:0] p2_gpio_sel,
    output logic [7:0] p3_gpio_sel,
    output logic [7:0] p4_gpio_sel,
    output logic [7:0] p1_reserved_sel,
    output logic [7:0] p2_reserved_sel,
    output logic [7:0] p3_reserved_sel,
    output logic [7:0] p4_reserved_sel,
    output logic [7:0] analog_in_chan_sel,
    output logic sync_serial0_select_sel,
    output logic sync_serial0_mosi_sel,
    output logic sync_serial0_miso_sel,
    output logic sync_serial0_clock_sel,
    output logic uart1_receive_sel,
    output logic uart1_transmit_sel,
    output logic timer_two_ext_pin_sel,
    output logic timer_three_ext_pin_sel,
    output logic [7:0] ext_bus_addr_data_hi_sel,
    output logic [7:0] p2_pulse_out_sel,
    output logic uart0_receive_sel,
    output logic uart0_transmit_sel,
    output logic ext_irq_in_zero_sel,
    output logic ext_irq_in_one_sel,
    output logic ext_bus_mem_clock_sel,
    output logic timer_zero_ext_pin_sel,
    output logic timer_one_ext_pin_sel,
    output logic i2c_sda_sel,
    output logic i2c_scl_sel,
    output logic ext_bus_write_strobe_sel,
    output logic ext_bus_read_strobe_sel,
    output logic clock_out_pin_sel,
    output logic [3:0] p4_pulse_out_sel,
    output logic ext_bus_chip_select_sel,
    output logic ext_bus_addr_latch_sel,
    output logic debug_clock_pin_sel,
    output logic debug_data_pin_sel
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic pfs_fn_t pin_fn(input logic alt, input logic main);
        pin_fn = alt ? (main ? PFS_FN_RSVD : PFS_FN_ALT) // [RULE3]
                     : (main ? PFS_FN_MAIN : PFS_FN_GPIO);
    endfunction

    function automatic logic [7:0] fn_mask(input pfs_sel_t s, input pfs_fn_t f);
        logic [7:0] m;
        m = 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            m[i] = (pin_fn(s.alternate_select[i], s.main_select[i]) == f);
        end
        fn_mask = m;
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        pfs_state_t core;
        logic [7:0] schm1, schm2, schm3, schm4;
        logic [7:0] g1, g2, g3, g4;
        logic [7:0] r1, r2, r3, r4;
        logic [7:0] m1, a1, m2, a2, m3, a3, m4;
    } pfs_all_t;

    pfs_all_t st_r;
    pfs_all_t st_nxt;
    pfs_req_t req;
    pfs_sel_t [3:0] sel_w;
    logic [1:0] widx;
    logic hit;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        sel_w = st_r.core.sel;
        hit = 1'b1;
        widx = 2'd0;
        case (req.addr)
            `PFS_PORT1_FUNCTION_SELECT_OFS: widx = 2'd0;
            `PFS_PORT2_FUNCTION_SELECT_OFS: widx = 2'd1;
            `PFS_PORT3_FUNCTION_SELECT_OFS: widx = 2'd2;
            `PFS_PORT4_FUNCTION_SELECT_OFS: widx = 2'd3;
            default: hit = 1'b0;
        endcase
        if (req.wr && hit)
        begin
            sel_w[widx] = req.wdata[23:0]; // [RULE1] [RULE18]
        end
        st_nxt.core.sel = sel_w;
        st_nxt.core.rdata = 32'h0000_0000;
        if (req.rd && hit)
        begin
            st_nxt.core.rdata = {8'h00, st_r.core.sel[widx]}; // [RULE18]
        end
        st_nxt.schm1 = sel_w[0].schmitt_input_enable; // [RULE2]
        st_nxt.schm2 = sel_w[1].schmitt_input_enable; // [RULE2]
        st_nxt.schm3 = sel_w[2].schmitt_input_enable; // [RULE2]
        st_nxt.schm4 = sel_w[3].schmitt_input_enable; // [RULE2]
        st_nxt.g1 = fn_mask(sel_w[0], PFS_FN_GPIO); // [RULE3]
        st_nxt.g2 = fn_mask(sel_w[1], PFS_FN_GPIO);
        st_nxt.g3 = fn_mask(sel_w[2], PFS_FN_GPIO);
        st_nxt.g4 = fn_mask(sel_w[3], PFS_FN_GPIO);
        st_nxt.m1 = fn_mask(sel_w[0], PFS_FN_MAIN);
        st_nxt.a1 = fn_mask(sel_w[0], PFS_FN_ALT);
        st_nxt.m2 = fn_mask(sel_w[1], PFS_FN_MAIN);
        st_nxt.a2 = fn_mask(sel_w[1], PFS_FN_ALT);
        st_nxt.m3 = fn_mask(sel_w[2], PFS_FN_MAIN);
        st_nxt.a3 = fn_mask(sel_w[2], PFS_FN_ALT);
        st_nxt.m4 = fn_mask(sel_w[3], PFS_FN_MAIN);
        // reserved combinations: both set, plus alt on the pins that lack one
        st_nxt.r1 = fn_mask(sel_w[0], PFS_FN_RSVD);
        st_nxt.r2 = fn_mask(sel_w[1], PFS_FN_RSVD);
        st_nxt.r3 = fn_mask(sel_w[2], PFS_FN_RSVD)
                  | (fn_mask(sel_w[2], PFS_FN_ALT) & 8'h87); // [RULE9]
        st_nxt.r4 = fn_mask(sel_w[3], PFS_FN_RSVD)
                  | fn_mask(sel_w[3], PFS_FN_ALT); // [RULE13] [RULE14] [RULE15]
        if (!rst_n)
        begin
            st_nxt = '0;
            st_nxt.core.sel[0] = `PFS_PORT123_RST; // [RULE17]
            st_nxt.core.sel[1] = `PFS_PORT123_RST; // [RULE17]
            st_nxt.core.sel[2] = `PFS_PORT123_RST; // [RULE17]
            st_nxt.core.sel[3] = `PFS_PORT4_RST; // [RULE16]
            st_nxt.g1 = 8'hff;
            st_nxt.g2 = 8'hff;
            st_nxt.g3 = 8'hff;
            st_nxt.g4 = 8'h3f;
            st_nxt.m4 = 8'hc0; // [RULE16]
        end
    end

    always_ff @(posedge sys_clk)
    begin
        st_r <= st_nxt;
    end

    // ----------------------------------------
    // outputs, all straight from st_r
    // ----------------------------------------
    assign reg_rdata = st_r.core.rdata;
    assign p1_schmitt_input_enable = st_r.schm1;
    assign p2_schmitt_input_enable = st_r.schm2;
    assign p3_schmitt_input_enable = st_r.schm3;
    assign p4_schmitt_input_enable = st_r.schm4;
    assign p1_gpio_sel = st_r.g1;
    assign p2_gpio_sel = st_r.g2;
    assign p3_gpio_sel = st_r.g3;
    assign p4_gpio_sel = st_r.g4;
    assign p1_reserved_sel = st_r.r1;
    assign p2_reserved_sel = st_r.r2;
    assign p3_reserved_sel = st_r.r3;
    assign p4_reserved_sel = st_r.r4;

    // port 1
    assign analog_in_chan_sel = st_r.m1; // [RULE4]
    assign sync_serial0_select_sel = st_r.a1[4]; // [RULE5]
    assign sync_serial0_mosi_sel = st_r.a1[5]; // [RULE5]
    assign sync_serial0_miso_sel = st_r.a1[6]; // [RULE5]
    assign sync_serial0_clock_sel = st_r.a1[7]; // [RULE5]
    assign timer_two_ext_pin_sel = st_r.a1[0]; // [RULE6]
    assign timer_three_ext_pin_sel = st_r.a1[1]; // [RULE6]
    assign uart1_receive_sel = st_r.a1[2]; // [RULE6]
    assign uart1_transmit_sel = st_r.a1[3]; // [RULE6]

    // port 2
    assign ext_bus_addr_data_hi_sel = st_r.m2; // [RULE7]
    assign p2_pulse_out_sel = st_r.a2; // [RULE8]

    // port 3
    assign uart0_receive_sel = st_r.m3[0]; // [RULE9]
    assign uart0_transmit_sel = st_r.m3[1]; // [RULE9]
    assign ext_irq_in_zero_sel = st_r.m3[2]; // [RULE10]
    assign ext_irq_in_one_sel = st_r.m3[3]; // [RULE10]
    assign ext_bus_mem_clock_sel = st_r.a3[3]; // [RULE10]
    assign timer_zero_ext_pin_sel = st_r.m3[4]; // [RULE11]
    assign timer_one_ext_pin_sel = st_r.m3[5]; // [RULE11]
    assign i2c_sda_sel = st_r.a3[4]; // [RULE11]
    assign i2c_scl_sel = st_r.a3[5]; // [RULE11]
    assign ext_bus_write_strobe_sel = st_r.m3[6]; // [RULE12]
    assign ext_bus_read_strobe_sel = st_r.m3[7]; // [RULE12]
    assign clock_out_pin_sel = st_r.a3[6]; // [RULE12]

    // port 4
    assign p4_pulse_out_sel = st_r.m4[3:0]; // [RULE13]
    assign ext_bus_chip_select_sel = st_r.m4[4]; // [RULE14]
    assign ext_bus_addr_latch_sel = st_r.m4[5]; // [RULE14]
    assign debug_clock_pin_sel = st_r.m4[6]; // [RULE15]
    assign debug_data_pin_sel = st_r.m4[7]; // [RULE15]

endmodule // pfs_port_function_select

`default_nettype wire

// file: sim/pfs_sel_properties.sv
/*
 concurrent checks on the register port and port 1, 2 and 4 decode.
 assumes binding to pfs_port_function_select, synchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module pfs_sel_properties (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [7:0] p2_schmitt_input_enable,
    input wire logic [7:0] p2_gpio_sel,
    input wire logic [7:0] p2_reserved_sel,
    input wire logic [7:0] ext_bus_addr_data_hi_sel,
    input wire logic [7:0] p2_pulse_out_sel,
    input wire logic [7:0] analog_in_chan_sel,
    input wire logic debug_clock_pin_sel
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    logic [31:0] wd_q;
    always_ff @(posedge sys_clk) wd_q <= reg_wdata;
    sequence s_p2_wr;
        reg_wr && reg_addr == 8'h38;
    endsequence
    sequence s_p4_wr;
        reg_wr && reg_addr == 8'h40;
    endsequence
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data not zero");
    a_rsvd_zero: assert property (reg_rd |=> reg_rdata[31:24] == 8'h00)
        else $error("reserved bits not zero");
    a_p2_main: assert property (s_p2_wr |=> ext_bus_addr_data_hi_sel == (wd_q[7:0] & ~wd_q[15:8]))
        else $error("bus data route wrong");
    a_p2_alt: assert property (s_p2_wr |=> p2_pulse_out_sel == (wd_q[15:8] & ~wd_q[7:0]))
        else $error("pwm route wrong");
    a_p2_gpio_rsvd: assert property (s_p2_wr |=>
        {p2_reserved_sel, p2_gpio_sel} == {wd_q[15:8] & wd_q[7:0], ~(wd_q[15:8] | wd_q[7:0])})
        else $error("gpio or reserved decode wrong");
    a_schmitt_en: assert property (s_p2_wr |=> p2_schmitt_input_enable == wd_q[23:16])
        else $error("schmitt enable wrong");
    a_p2_hold: assert property (!(reg_wr && reg_addr == 8'h38) |=> $stable(p2_pulse_out_sel))
        else $error("pwm select moved");
    a_analog_route: assert property (reg_wr && reg_addr == 8'h34 |=>
        analog_in_chan_sel == (wd_q[7:0] & ~wd_q[15:8]))
        else $error("analog route wrong");
    a_debug_clk: assert property (s_p4_wr |=> debug_clock_pin_sel == (wd_q[6] & ~wd_q[14]))
        else $error("debug clock route wrong");
    a_p4_readback: assert property (s_p4_wr ##1 !reg_wr ##1 (reg_rd && reg_addr == 8'h40) |=>
        reg_rdata == ($past(reg_wdata, 3) & 32'h00ff_ffff))
        else $error("port 4 readback wrong");
endmodule // pfs_sel_properties
bind pfs_port_function_select pfs_sel_properties u_props (.sys_clk, .rst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .p2_schmitt_input_enable, .p2_gpio_sel,
    .p2_reserved_sel, .ext_bus_addr_data_hi_sel, .p2_pulse_out_sel, .analog_in_chan_sel,
    .debug_clock_pin_sel);
`default_nettype wire

// file: sim/pfs_pin_model.sv
/*
 port 3 pad model: flags each pad claimed by exactly one owner.
 assumes the decoded port 3 selects of the function select block.
*/
`timescale 1ns/10ps
`default_nettype none
module pfs_pin_model (
    input wire logic [7:0] p3_gpio_sel,
    input wire logic [7:0] p3_reserved_sel,
    input wire logic uart0_receive_sel,
    input wire logic uart0_transmit_sel,
    input wire logic ext_irq_in_zero_sel,
    input wire logic ext_irq_in_one_sel,
    input wire logic ext_bus_mem_clock_sel,
    input wire logic timer_zero_ext_pin_sel,
    input wire logic timer_one_ext_pin_sel,
    input wire logic i2c_sda_sel,
    input wire logic i2c_scl_sel,
    input wire logic ext_bus_write_strobe_sel,
    input wire logic ext_bus_read_strobe_sel,
    input wire logic clock_out_pin_sel,
    output logic [7:0] one_owner
);
    logic [7:0] g;
    logic [7:0] r;
    assign g = p3_gpio_sel;
    assign r = p3_reserved_sel;
    assign one_owner[0] = $onehot({g[0], r[0], uart0_receive_sel});
    assign one_owner[1] = $onehot({g[1], r[1], uart0_transmit_sel});
    assign one_owner[2] = $onehot({g[2], r[2], ext_irq_in_zero_sel});
    assign one_owner[3] = $onehot({g[3], r[3], ext_irq_in_one_sel, ext_bus_mem_clock_sel});
    assign one_owner[4] = $onehot({g[4], r[4], timer_zero_ext_pin_sel, i2c_sda_sel});
    assign one_owner[5] = $onehot({g[5], r[5], timer_one_ext_pin_sel, i2c_scl_sel});
    assign one_owner[6] = $onehot({g[6], r[6], ext_bus_write_strobe_sel, clock_out_pin_sel});
    assign one_owner[7] = $onehot({g[7], r[7], ext_bus_read_strobe_sel});
endmodule // pfs_pin_model
`default_nettype wire

// file: sim/test_port_function_select.sv
/*
 self-checking bench for the port function select block.
 assumes the design, its package and the pin model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module test_port_function_select;
    logic sys_clk, rst_n, reg_wr, reg_rd;
    logic [7:0] reg_addr, one_owner;
    logic [31:0] reg_wdata, reg_rdata;
    logic [7:0] p1_schmitt_input_enable, p2_schmitt_input_enable, p3_schmitt_input_enable;
    logic [7:0] p4_schmitt_input_enable, p1_gpio_sel, p2_gpio_sel, p3_gpio_sel, p4_gpio_sel;
    logic [7:0] p1_reserved_sel, p2_reserved_sel, p3_reserved_sel, p4_reserved_sel;
    logic [7:0] analog_in_chan_sel, ext_bus_addr_data_hi_sel, p2_pulse_out_sel;
    logic [3:0] p4_pulse_out_sel;
    logic sync_serial0_select_sel, sync_serial0_mosi_sel, sync_serial0_miso_sel;
    logic sync_serial0_clock_sel, uart1_receive_sel, uart1_transmit_sel, timer_two_ext_pin_sel;
    logic timer_three_ext_pin_sel, uart0_receive_sel, uart0_transmit_sel, ext_irq_in_zero_sel;
    logic ext_irq_in_one_sel, ext_bus_mem_clock_sel, timer_zero_ext_pin_sel, i2c_sda_sel;
    logic timer_one_ext_pin_sel, i2c_scl_sel, ext_bus_write_strobe_sel, ext_bus_read_strobe_sel;
    logic clock_out_pin_sel, ext_bus_chip_select_sel, ext_bus_addr_latch_sel;
    logic debug_clock_pin_sel, debug_data_pin_sel;
    int err_total = 0;
    int checked = 0;
    pfs_port_function_select dut (.*);
    pfs_pin_model u_pins (.*);
    always #5 sys_clk = ~sys_clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    task automatic complete_run;
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic t_reset;
        rdc(8'h34, 32'h0000_0000);
        rdc(8'h38, 32'h0000_0000);
        rdc(8'h3c, 32'h0000_0000);
        rdc(8'h40, 32'h0000_00c0);
        chk(32'({debug_clock_pin_sel, debug_data_pin_sel, p4_gpio_sel, p1_gpio_sel}), 32'h0003_3fff);
    endtask
    task automatic t_port1;
        wr(8'h34, 32'hffa5_0ff0);
        rdc(8'h34, 32'h00a5_0ff0);
        chk(32'({p1_schmitt_input_enable, analog_in_chan_sel, p1_gpio_sel}), 32'h00a5_f000);
        chk(32'({timer_two_ext_pin_sel, timer_three_ext_pin_sel, uart1_receive_sel,
            uart1_transmit_sel, sync_serial0_select_sel, sync_serial0_mosi_sel,
            sync_serial0_miso_sel, sync_serial0_clock_sel}), 32'h0000_00f0);
        wr(8'h34, 32'h0000_f000);
        chk(32'({uart1_transmit_sel, sync_serial0_select_sel, sync_serial0_mosi_sel,
            sync_serial0_miso_sel, sync_serial0_clock_sel}), 32'h0000_000f);
    endtask
    task automatic t_port2;
        wr(8'h38, 32'h0000_0f3c);
        chk({ext_bus_addr_data_hi_sel, p2_pulse_out_sel, p2_reserved_sel, p2_gpio_sel},
            32'h3003_0cc0);
    endtask
    task automatic t_port3(input logic [31:0] d, input logic [31:0] exp);
        wr(8'h3c, d);
        chk(32'({p3_reserved_sel, p3_gpio_sel, uart0_receive_sel, uart0_transmit_sel,
            ext_irq_in_zero_sel, ext_irq_in_one_sel, ext_bus_mem_clock_sel, timer_zero_ext_pin_sel,
            timer_one_ext_pin_sel, i2c_sda_sel, i2c_scl_sel, ext_bus_write_strobe_sel,
            ext_bus_read_strobe_sel, clock_out_pin_sel}), exp);
        chk(32'(one_owner), 32'h0000_00ff);
    endtask
    task automatic t_port4;
        wr(8'h40, 32'h0000_00ff);
        chk(32'({p4_pulse_out_sel, ext_bus_chip_select_sel, ext_bus_addr_latch_sel,
            debug_clock_pin_sel, debug_data_pin_sel, p4_reserved_sel, p4_gpio_sel}),
            32'h00ff_0000);
        wr(8'h40, 32'h005a_ff0f);
        rdc(8'h40, 32'h005a_ff0f);
        chk(32'({p3_schmitt_input_enable, p4_schmitt_input_enable}), 32'h0000_005a);
        chk(32'({p4_pulse_out_sel, debug_clock_pin_sel, p4_reserved_sel}), 32'h0000_00ff);
        wr(8'h44, 32'h0000_ffff);
        rdc(8'h44, 32'h0000_0000);
        rdc(8'h40, 32'h005a_ff0f);
    endtask
    initial
    begin
        sys_clk = 1'b0;
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_port1();
        t_port2();
        t_port3(32'h0000_38c7, 32'h0000_0e9e);
        t_port3(32'h0000_4138, 32'h0018_6161);
        t_port4();
        complete_run();
    end
    initial
    begin
        repeat (2000) @(posedge sys_clk);
        err_total++;
        complete_run();
    end
endmodule // test_port_function_select
`default_nettype wire
